// file: rtl/frsc_pkg.sv
// package: command codes, reset values and shared types for the command block
// Summary of operation
// RULE_01: memory read command starts pixel readback
// RULE_02: readback reloads column and page counters
// RULE_03: any other command aborts readback
// RULE_04: readback pixels always 18-bit coded
// RULE_05: frame memory untouched by any reset
// RULE_06: partial area takes four bytes, two rows
// RULE_07: partial rows are frame memory row addresses
// RULE_08: equal start and end gives one row
// RULE_09: host keeps partial rows within 1..13fh
// RULE_10: scrolling takes six bytes, three counts
// RULE_11: order clear: top fixed counted from top
// RULE_12: order set: top fixed counted from bottom
// RULE_13: scroll values count frame memory lines
// RULE_14: sync-off disables output, rests low
// RULE_15: sync-off when already off changes nothing
// RULE_16: sync-on takes mode byte, bit zero
// RULE_17: mode 0 vblank only, 1 adds hblank
// RULE_18: sync timing ignores line refresh order
// RULE_19: sleep with sync on holds pin low
// RULE_20: sync-on when already on has no effect
// RULE_21: commands accepted in every power mode
// RULE_22: access control bit 4 is refresh order
// RULE_23: access control bit 7 is page order
// RULE_24: end below start wraps through row zero
package frsc_pkg;
   localparam logic [7:0]  CMD_MEM_READ     = 8'h2e;
   localparam logic [7:0]  CMD_PARTIAL      = 8'h30;
   localparam logic [7:0]  CMD_VSCROLL      = 8'h33;
   localparam logic [7:0]  CMD_SYNC_OFF     = 8'h34;
   localparam logic [7:0]  CMD_SYNC_ON      = 8'h35;
   localparam int          LINE_ORDER_POS   = 4;
   localparam int          PAGE_ORDER_POS   = 7;
   localparam int          MODE_POS         = 0;
   localparam logic [15:0] PART_FIRST_RST   = 16'h0000;
   localparam logic [15:0] PART_LAST_RST    = 16'h013f;
   localparam logic [15:0] TOP_FIXED_RST    = 16'h0000;
   localparam logic [15:0] SCROLL_H_RST     = 16'h0140;
   localparam logic [15:0] BOT_FIXED_RST    = 16'h0000;
   localparam logic [7:0]  SYNC_MODE_RST    = 8'h00;
   localparam logic [15:0] LAST_ROW         = 16'h013f;
   localparam logic [15:0] LAST_COL         = 16'h00ef;
   localparam int          PIXEL_W          = 18;
   localparam int          FIFO_DEPTH       = 16;

   typedef enum logic [2:0] {FRSC_IDLE, FRSC_PART, FRSC_SCRL, FRSC_SYNC, FRSC_READ} frsc_state_e;

   // one host interface byte
   typedef struct packed {
      logic       is_cmd;
      logic [7:0] data;
   } frsc_byte_s;

   // scrolling definition block
   typedef struct packed {
      logic [15:0] top_fixed;
      logic [15:0] height;
      logic [15:0] bot_fixed;
   } frsc_scroll_s;
endpackage

// file: rtl/frsc_fifo.sv
// module: parameterised flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
module frsc_fifo #(
   parameter int WIDTH = 18,
   parameter int DEPTH = 16
) (
   // clock and reset
   input  wire logic             ref_clk,
   input  wire logic             arst_n,
   input  wire logic             flush,
   // fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wp;
      logic [AW-1:0]               rp;
      logic [AW:0]                 cnt;
   } frsc_fifo_s;

   frsc_fifo_s st_r, st_nxt;     // whole state
   logic       push, pop;        // handshakes

   assign in_ready  = (st_r.cnt != (AW+1)'(DEPTH));
   assign out_valid = (st_r.cnt != '0);
   assign out_data  = st_r.mem[st_r.rp];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // next state: store, advance pointers, count
   always_comb begin
      st_nxt = st_r;
      if (push) begin
         st_nxt.mem[st_r.wp] = in_data;
         st_nxt.wp = st_r.wp + 1'b1;
      end
      if (pop) begin
         st_nxt.rp = st_r.rp + 1'b1;
      end
      st_nxt.cnt = st_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
      if (flush) begin
         st_nxt.wp  = '0;
         st_nxt.rp  = '0;
         st_nxt.cnt = '0;
      end
   end

   // register the state
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   a_fifo_no_over: assert property (@(posedge ref_clk) disable iff (!arst_n)
      st_r.cnt <= (AW+1)'(DEPTH)) else $error("fifo count above depth");
endmodule // frsc_fifo

// file: rtl/frsc_sync_gen.sv
// module: tearing sync output shaping from blanking inputs
`timescale 1ns/1ps
module frsc_sync_gen (
   // clock and reset
   input  wire logic ref_clk,
   input  wire logic arst_n,
   // control
   input  wire logic enable,
   input  wire logic mode_hv,
   input  wire logic sleep_in,
   // blanking from the timing generator
   input  wire logic vblank,
   input  wire logic hblank,
   // pin
   output logic      sync_out
);
   typedef struct packed {
      logic pin;
   } frsc_sg_s;

   frsc_sg_s st_r, st_nxt;   // pin flop

   // pin level; line refresh order deliberately not an input (see RULE_18)
   always_comb begin
      st_nxt.pin = 1'b0;                                   // see RULE_14
      if (enable && !sleep_in) begin                       // see RULE_19
         st_nxt.pin = vblank || (mode_hv && hblank);       // see RULE_17
      end
   end

   // register
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end
   assign sync_out = st_r.pin;

   a_sync_sleep_low: assert property (@(posedge ref_clk) disable iff (!arst_n)
      $past(sleep_in) |-> !sync_out) else $error("sync pin high in sleep"); // see RULE_19
   a_sync_vonly: assert property (@(posedge ref_clk) disable iff (!arst_n)
      $past(enable && !sleep_in && !mode_hv && !vblank) |-> !sync_out)
      else $error("hblank seen in vblank-only mode"); // see RULE_17
endmodule // frsc_sync_gen

// file: rtl/frsc_cmd.sv
// module: command decoder for readback, partial area, scrolling and tearing sync
`timescale 1ns/1ps
module frsc_cmd #(
   parameter int PIXEL_W = frsc_pkg::PIXEL_W,
   parameter int DEPTH   = frsc_pkg::FIFO_DEPTH
) (
   // clock and reset
   input  wire logic               ref_clk,
   input  wire logic               arst_n,
   input  wire logic               soft_rst,
   // host byte stream
   input  wire logic               host_valid,
   input  wire logic               host_is_cmd,
   input  wire logic [7:0]         host_data,
   // access control and mode state from elsewhere
   input  wire logic [7:0]         memory_access_control,
   input  wire logic               sleep_in,
   // frame memory read port
   output logic                    fm_rd_en,
   output logic [15:0]             fm_col,
   output logic [15:0]             fm_page,
   input  wire logic [PIXEL_W-1:0] fm_rd_data,
   // readback to host
   output logic                    rd_valid,
   input  wire logic               rd_ready,
   output logic [PIXEL_W-1:0]      rd_data,
   // blanking inputs and sync pin
   input  wire logic               vblank,
   input  wire logic               hblank,
   output logic                    tear_sync_output,
   // configuration out
   output logic [15:0]             partial_first_row,
   output logic [15:0]             partial_last_row,
   output logic                    partial_wraps,
   output frsc_pkg::frsc_scroll_s  scroll_def,
   output logic                    line_refresh_order
);
   ////////////////////////////////////////////////////////////////////////
   // state
   typedef struct packed {
      frsc_pkg::frsc_state_e st;
      logic [2:0]            idx;
      logic [7:0]            hi;
      logic [15:0]           p_first;
      logic [15:0]           p_last;
      logic                  wraps;
      frsc_pkg::frsc_scroll_s scr;
      logic [7:0]            mode_param;
      logic                  sync_en;
      logic [15:0]           col;
      logic [15:0]           page;
      logic                  rd_en;
      logic                  pend;
      logic                  lro;
   } frsc_cmd_s;

   frsc_cmd_s  st_r, st_nxt;   // whole control state
   logic       cmd_seen;       // command byte arrives
   logic       par_seen;       // parameter byte arrives
   logic       fifo_ready;     // readback fifo space
   logic       abort;          // readback cancelled
   logic [15:0] word;          // assembled parameter
   logic       page_up;        // page order bit
   logic       fifo_in_valid;  // data return one cycle after read

   assign cmd_seen = host_valid && host_is_cmd;
   assign par_seen = host_valid && !host_is_cmd;
   assign word     = {st_r.hi, host_data};
   assign page_up  = memory_access_control[frsc_pkg::PAGE_ORDER_POS];
   assign abort    = cmd_seen && st_r.st == frsc_pkg::FRSC_READ;           // see RULE_03
   assign fifo_in_valid = st_r.pend && !abort;

   ////////////////////////////////////////////////////////////////////////
   // next state; every command is taken regardless of power mode (see RULE_21)
   always_comb begin
      st_nxt       = st_r;
      st_nxt.rd_en = 1'b0;
      st_nxt.pend  = st_r.rd_en;
      st_nxt.lro   = memory_access_control[frsc_pkg::LINE_ORDER_POS];   // see RULE_22
      if (cmd_seen) begin
         st_nxt.idx  = '0;
         st_nxt.pend = 1'b0;
         case (host_data)
            frsc_pkg::CMD_MEM_READ: begin
               st_nxt.st   = frsc_pkg::FRSC_READ;                        // see RULE_01
               st_nxt.col  = '0;                                         // see RULE_02
               st_nxt.page = page_up ? frsc_pkg::LAST_ROW : 16'h0000;    // see RULE_23
            end
            frsc_pkg::CMD_PARTIAL: st_nxt.st = frsc_pkg::FRSC_PART;
            frsc_pkg::CMD_VSCROLL: st_nxt.st = frsc_pkg::FRSC_SCRL;
            frsc_pkg::CMD_SYNC_OFF: begin
               st_nxt.st      = frsc_pkg::FRSC_IDLE;
               st_nxt.sync_en = 1'b0;                                    // see RULE_14 RULE_15
            end
            frsc_pkg::CMD_SYNC_ON: begin
               // already on: parameter is swallowed without effect
               st_nxt.st = st_r.sync_en ? frsc_pkg::FRSC_IDLE : frsc_pkg::FRSC_SYNC; // see RULE_20
            end
            default: st_nxt.st = frsc_pkg::FRSC_IDLE;
         endcase
      end else begin
         case (st_r.st)
            frsc_pkg::FRSC_PART: if (par_seen) begin                     // see RULE_06
               st_nxt.idx = st_r.idx + 3'h1;
               st_nxt.hi  = host_data;
               if (st_r.idx == 3'h1) st_nxt.p_first = word;              // see RULE_07
               if (st_r.idx == 3'h3) begin
                  st_nxt.p_last = word;
                  st_nxt.wraps  = word < st_r.p_first;                   // see RULE_24 RULE_08
                  st_nxt.st     = frsc_pkg::FRSC_IDLE;
               end
            end
            frsc_pkg::FRSC_SCRL: if (par_seen) begin                     // see RULE_10
               st_nxt.idx = st_r.idx + 3'h1;
               st_nxt.hi  = host_data;
               // raw frame memory line counts (see RULE_13)
               if (st_r.idx == 3'h1) st_nxt.scr.top_fixed = word;
               if (st_r.idx == 3'h3) st_nxt.scr.height    = word;
               if (st_r.idx == 3'h5) begin
                  st_nxt.scr.bot_fixed = word;
                  st_nxt.st = frsc_pkg::FRSC_IDLE;
               end
            end
            frsc_pkg::FRSC_SYNC: if (par_seen) begin                     // see RULE_16
               st_nxt.mode_param = host_data;
               st_nxt.sync_en    = 1'b1;
               st_nxt.st         = frsc_pkg::FRSC_IDLE;
            end
            frsc_pkg::FRSC_READ: if (fifo_ready && !st_r.rd_en && !st_r.pend) begin
               // one read in flight keeps the fifo from overflowing
               st_nxt.rd_en = 1'b1;                                      // see RULE_01
            end else if (st_r.rd_en) begin
               if (st_r.col == frsc_pkg::LAST_COL) begin
                  st_nxt.col  = '0;
                  st_nxt.page = page_up ? st_r.page - 16'h1 : st_r.page + 16'h1;
               end else begin
                  st_nxt.col = st_r.col + 16'h1;
               end
            end
            frsc_pkg::FRSC_IDLE: st_nxt.idx = '0;
            default: st_nxt.st = frsc_pkg::FRSC_IDLE;
         endcase
      end
      if (soft_rst) begin
         // frame memory itself is never cleared here (see RULE_05)
         st_nxt.st      = frsc_pkg::FRSC_IDLE;
         st_nxt.p_first = frsc_pkg::PART_FIRST_RST;
         st_nxt.p_last  = frsc_pkg::PART_LAST_RST;
         st_nxt.wraps   = 1'b0;
         st_nxt.scr     = {frsc_pkg::TOP_FIXED_RST, frsc_pkg::SCROLL_H_RST,
                           frsc_pkg::BOT_FIXED_RST};
         st_nxt.sync_en    = 1'b0;
         st_nxt.mode_param = frsc_pkg::SYNC_MODE_RST;
         st_nxt.rd_en = 1'b0;
         st_nxt.pend  = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // register the state
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_r            <= '0;
         st_r.st         <= frsc_pkg::FRSC_IDLE;
         st_r.p_first    <= frsc_pkg::PART_FIRST_RST;
         st_r.p_last     <= frsc_pkg::PART_LAST_RST;
         st_r.scr.top_fixed <= frsc_pkg::TOP_FIXED_RST;
         st_r.scr.height    <= frsc_pkg::SCROLL_H_RST;
         st_r.scr.bot_fixed <= frsc_pkg::BOT_FIXED_RST;
         st_r.mode_param <= frsc_pkg::SYNC_MODE_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // readback fifo, always full 18-bit pixels (see RULE_04)
   frsc_fifo #(
      .WIDTH (PIXEL_W),
      .DEPTH (DEPTH)
   ) u_fifo (
      .ref_clk   (ref_clk),
      .arst_n    (arst_n),
      .flush     (abort || soft_rst),                                    // see RULE_03
      .in_valid  (fifo_in_valid),
      .in_ready  (fifo_ready),
      .in_data   (fm_rd_data),
      .out_valid (rd_valid),
      .out_ready (rd_ready),
      .out_data  (rd_data)
   );

   // tearing sync pin; order bit is not routed in (see RULE_18)
   frsc_sync_gen u_sync (
      .ref_clk  (ref_clk),
      .arst_n   (arst_n),
      .enable   (st_r.sync_en),
      .mode_hv  (st_r.mode_param[frsc_pkg::MODE_POS]),                   // see RULE_17
      .sleep_in (sleep_in),
      .vblank   (vblank),
      .hblank   (hblank),
      .sync_out (tear_sync_output)
   );

   ////////////////////////////////////////////////////////////////////////
   // outputs straight from flops; scroll counts read per order bit (see RULE_11 RULE_12)
   assign fm_rd_en           = st_r.rd_en;
   assign fm_col             = st_r.col;
   assign fm_page            = st_r.page;
   assign partial_first_row  = st_r.p_first;
   assign partial_last_row   = st_r.p_last;
   assign partial_wraps      = st_r.wraps;
   assign scroll_def         = st_r.scr;
   assign line_refresh_order = st_r.lro;

   ////////////////////////////////////////////////////////////////////////
   // assertions
   a_read_reload: assert property (@(posedge ref_clk) disable iff (!arst_n) // see RULE_02
      (cmd_seen && host_data == frsc_pkg::CMD_MEM_READ && !soft_rst) |=>
      (fm_col == 16'h0000 && st_r.st == frsc_pkg::FRSC_READ))
      else $error("readback did not reload counters");
   a_read_start: assert property (@(posedge ref_clk) disable iff (!arst_n) // see RULE_01
      (cmd_seen && host_data == frsc_pkg::CMD_MEM_READ && !soft_rst)
      ##1 (!host_valid && !soft_rst && fifo_ready)[*2] |-> ##[0:2] fm_rd_en)
      else $error("readback did not start");
   a_read_abort: assert property (@(posedge ref_clk) disable iff (!arst_n) // see RULE_03
      abort |=> (st_r.st != frsc_pkg::FRSC_READ || fm_col == 16'h0000) && !fm_rd_en)
      else $error("readback not aborted");
   a_sync_off: assert property (@(posedge ref_clk) disable iff (!arst_n) // see RULE_14
      (cmd_seen && host_data == frsc_pkg::CMD_SYNC_OFF) |=> ##1 !tear_sync_output)
      else $error("sync pin active after off");
   a_sync_on_keep: assert property (@(posedge ref_clk) disable iff (!arst_n) // see RULE_20
      (cmd_seen && host_data == frsc_pkg::CMD_SYNC_ON && st_r.sync_en && !soft_rst)
      ##1 par_seen |=> $stable(st_r.mode_param))
      else $error("sync on changed mode while on");
   a_partial_load: assert property (@(posedge ref_clk) disable iff (!arst_n) // see RULE_06
      (st_r.st == frsc_pkg::FRSC_PART && st_r.idx == 3'h3 && par_seen && !soft_rst)
      |=> partial_last_row == $past(word) && st_r.st == frsc_pkg::FRSC_IDLE)
      else $error("partial end row not loaded");
   a_partial_wrap: assert property (@(posedge ref_clk) disable iff (!arst_n) // see RULE_24
      // rows land one at a time, so the pair is only judged outside the command
      (partial_wraps && st_r.st != frsc_pkg::FRSC_PART) |-> partial_last_row < partial_first_row)
      else $error("wrap flag without end below start");
   a_scroll_load: assert property (@(posedge ref_clk) disable iff (!arst_n) // see RULE_10
      (st_r.st == frsc_pkg::FRSC_SCRL && st_r.idx == 3'h5 && par_seen && !soft_rst)
      |=> scroll_def.bot_fixed == $past(word))
      else $error("bottom fixed count not loaded");
   c_readback: cover property (@(posedge ref_clk) rd_valid && rd_ready);
   c_abort: cover property (@(posedge ref_clk) abort);
   c_sync_hv: cover property (@(posedge ref_clk) st_r.sync_en && st_r.mode_param[0]);
   c_wrap: cover property (@(posedge ref_clk) partial_wraps);
endmodule // frsc_cmd

// file: sim/frsc_fm_model.sv
// frame memory model answering the command block's read port
`timescale 1ns/1ps
module frsc_fm_model (
   // clock
   input  wire logic        ref_clk,
   // read port from the block
   input  wire logic        fm_rd_en,
   input  wire logic [15:0] fm_col,
   input  wire logic [15:0] fm_page,
   output logic [17:0]      fm_rd_data
);
   ////////////////////////////////////////////////////////////////////////////////
   // contents are a pure function of address, so no reset touches them
   // one 18-bit pixel per address
   // outside a read cycle the data inverts, so a late capture shows wrong data
   initial fm_rd_data = 18'h00000;
   always @(posedge ref_clk) begin
      if (fm_rd_en === 1'b1) begin
         fm_rd_data <= {fm_page[8:0], fm_col[8:0]};  // valid the cycle after the strobe
      end else begin
         fm_rd_data <= ~fm_rd_data;  // stale value never held
      end
   end
endmodule // frsc_fm_model

// file: sim/frsc_cmd_bench.sv
// testbench: host bytes, blanking and readback around the command block
`timescale 1ns/1ps
module frsc_cmd_bench;
   ////////////////////////////////////////////////////////////////////////////////
   // signals
   logic                  ref_clk, arst_n, soft_rst;                // clock, resets
   logic                  host_valid, host_is_cmd;                  // host byte strobe
   logic [7:0]            host_data, memory_access_control;         // byte, access control
   logic                  sleep_in, vblank, hblank, rd_ready;       // levels and drain
   logic                  fm_rd_en, rd_valid, tear_sync_output;     // outputs
   logic [15:0]           fm_col, fm_page;                          // read address
   logic [17:0]           fm_rd_data, rd_data;                      // pixels
   logic [15:0]           partial_first_row, partial_last_row;      // partial rows
   logic                  partial_wraps, line_refresh_order;        // flags
   frsc_pkg::frsc_scroll_s scroll_def;                              // scroll counts
   int                    err_count, checked, cycles, reads;        // bookkeeping

   ////////////////////////////////////////////////////////////////////////////////
   // design and frame memory
   frsc_cmd frsc_cmd_i (.ref_clk, .arst_n, .soft_rst, .host_valid, .host_is_cmd, .host_data,
      .memory_access_control, .sleep_in, .fm_rd_en, .fm_col, .fm_page, .fm_rd_data,
      .rd_valid, .rd_ready, .rd_data, .vblank, .hblank, .tear_sync_output,
      .partial_first_row, .partial_last_row, .partial_wraps, .scroll_def,
      .line_refresh_order);
   frsc_fm_model frsc_fm_model_i (.ref_clk, .fm_rd_en, .fm_col, .fm_page, .fm_rd_data);

   // clock at 50 ns period
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   // hang guard and read strobe count
   always @(negedge ref_clk) begin
      cycles++;
      if (fm_rd_en === 1'b1) reads++;
      if (cycles == 20000) begin
         err_count++;
         end_sim();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // helpers
   task automatic end_sim();
      $display("counts: %0d checks, %0d mismatches", checked, err_count);
      if (err_count == 0 && checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   // compare, zero-extended to 48 bits
   task automatic chk(input logic [47:0] got, input logic [47:0] exp, input string msg);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH at %0t: %s got %h exp %h", $time, msg, got, exp);
      end
   endtask

   // one host byte, back to back allowed
   task automatic put(input logic c, input logic [7:0] d);
      @(negedge ref_clk);
      host_valid = 1'b1;
      host_is_cmd = c;
      host_data = d;
   endtask

   // release the strobe, then wait n cycles
   task automatic idle(input int n);
      @(negedge ref_clk);
      host_valid = 1'b0;
      repeat (n) @(negedge ref_clk);
   endtask

   // drain n pixels of page pg starting at column 0, judged at the falling edge
   task automatic pull(input int n, input logic [15:0] pg);
      int w;
      logic [8:0] c;
      @(negedge ref_clk);
      rd_ready = 1'b1;
      for (int i = 0; i < n; i++) begin
         w = 0;
         c = i[8:0];
         while (rd_valid !== 1'b1 && w < 60) begin
            @(negedge ref_clk);
            w++;
         end
         chk(rd_data, {pg[8:0], c}, "readback pixel");
         @(negedge ref_clk);  // head word leaves at the rising edge passed here
      end
      rd_ready = 1'b0;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // scenarios
   task automatic t_reset();
      chk(partial_first_row, frsc_pkg::PART_FIRST_RST, "first row default");
      chk(partial_last_row, frsc_pkg::PART_LAST_RST, "last row default");
      chk(scroll_def, {16'h0000, 16'h0140, 16'h0000}, "scroll default");
      chk(tear_sync_output, 1'b0, "sync off at reset");
      $display("test reset done");
   endtask

   // rows kept within 1..13fh by the host
   task automatic t_partial();
      put(1, frsc_pkg::CMD_PARTIAL);
      put(0, 8'h00);
      put(0, 8'h05);
      put(0, 8'h00);
      put(0, 8'h05);
      idle(2);
      chk(partial_first_row, 16'h0005, "start row");
      chk(partial_last_row, 16'h0005, "end row");
      chk(partial_wraps, 1'b0, "one row region");
      put(1, frsc_pkg::CMD_PARTIAL);
      put(0, 8'h01);
      put(0, 8'h00);
      put(0, 8'h00);
      put(0, 8'h10);
      put(0, 8'h3f);  // surplus byte must be ignored
      idle(2);
      chk({partial_first_row, partial_last_row}, 32'h01000010, "rows kept");
      chk(partial_wraps, 1'b1, "wrapping region");
      $display("test partial done");
   endtask

   // accepted while asleep, order bit followed
   task automatic t_scroll();
      sleep_in = 1'b1;
      memory_access_control = 8'h10;
      put(1, frsc_pkg::CMD_VSCROLL);
      put(0, 8'h00);
      put(0, 8'h10);
      put(0, 8'h01);
      put(0, 8'h20);
      put(0, 8'h00);
      put(0, 8'h11);
      idle(2);
      chk(scroll_def, {16'h0010, 16'h0120, 16'h0011}, "scroll counts");
      chk(line_refresh_order, 1'b1, "order set");
      memory_access_control = 8'h00;
      idle(2);
      chk(line_refresh_order, 1'b0, "order clear");
      sleep_in = 1'b0;
      $display("test scroll done");
   endtask

   task automatic t_sync();
      vblank = 1'b1;
      idle(2);
      chk(tear_sync_output, 1'b0, "off ignores vblank");
      put(1, frsc_pkg::CMD_SYNC_ON);
      put(0, 8'hfe);  // upper bits are don't-care
      idle(2);
      chk(tear_sync_output, 1'b1, "vblank shown");
      vblank = 1'b0;
      hblank = 1'b1;
      put(1, frsc_pkg::CMD_SYNC_ON);
      put(0, 8'h01);  // already on: mode kept
      idle(2);
      chk(tear_sync_output, 1'b0, "hblank hidden, mode 0");
      vblank = 1'b1;
      memory_access_control = 8'h10;
      idle(2);
      chk(tear_sync_output, 1'b1, "order bit ignored");
      sleep_in = 1'b1;
      idle(2);
      chk(tear_sync_output, 1'b0, "low in sleep");
      sleep_in = 1'b0;
      put(1, frsc_pkg::CMD_SYNC_OFF);
      put(1, frsc_pkg::CMD_SYNC_OFF);
      idle(2);
      chk(tear_sync_output, 1'b0, "off twice");
      vblank = 1'b0;
      put(1, frsc_pkg::CMD_SYNC_ON);
      put(0, 8'h01);
      idle(2);
      chk(tear_sync_output, 1'b1, "mode 1 hblank");
      put(1, frsc_pkg::CMD_SYNC_OFF);
      idle(2);
      chk(tear_sync_output, 1'b0, "off again");
      hblank = 1'b0;
      memory_access_control = 8'h00;
      $display("test sync done");
   endtask

   // start page from page order bit, then abort
   task automatic t_read(input logic [7:0] mac, input logic [15:0] pg);
      memory_access_control = mac;
      put(1, frsc_pkg::CMD_MEM_READ);
      idle(0);
      pull(4, pg);
      put(1, frsc_pkg::CMD_SYNC_OFF);
      idle(4);
      chk(rd_valid, 1'b0, "abort flushes");
      $display("test read page %h done", pg);
   endtask

   // stalled drain fills the fifo, then drain in order
   task automatic t_fill();
      int r0;
      int r1;
      memory_access_control = 8'h00;
      r0 = reads;
      put(1, frsc_pkg::CMD_MEM_READ);
      idle(120);
      r1 = reads;
      idle(30);
      chk(reads - r1, 0, "reads stop when full");
      chk(r1 - r0, frsc_pkg::FIFO_DEPTH, "fifo filled");
      pull(20, 16'h0000);
      put(1, frsc_pkg::CMD_VSCROLL);
      idle(4);
      chk(rd_valid, 1'b0, "abort empties");
      $display("test fill done");
   endtask

   // software reset restores defaults
   task automatic t_soft();
      @(negedge ref_clk);
      soft_rst = 1'b1;
      @(negedge ref_clk);
      soft_rst = 1'b0;
      idle(1);
      chk({partial_first_row, partial_last_row}, 32'h0000013f, "rows restored");
      chk(scroll_def, {16'h0000, 16'h0140, 16'h0000}, "scroll restored");
      $display("test soft reset done");
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      {soft_rst, host_valid, host_is_cmd, sleep_in, vblank, hblank, rd_ready} = 7'h00;
      host_data = 8'h00;
      memory_access_control = 8'h00;
      {err_count, checked, cycles, reads} = {4{32'sd0}};
      arst_n = 1'b0;
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
      arst_n = 1'b1;
      t_reset();
      t_partial();
      t_scroll();
      t_sync();
      t_read(8'h00, 16'h0000);
      t_read(8'h80, frsc_pkg::LAST_ROW);
      t_fill();
      t_soft();
      end_sim();
   end
endmodule // frsc_cmd_bench
